// ===== srah_top.v
// Purpose: Service request and acknowledge handler of a parallel channel.
// Assumes: 50 MHz clock; register port with read data one cycle after strobe.
// Notes:   Sources arrive as level requests from channel and pipeline logic.
// Operation
// - Acknowledge read returns local vector register contents on data bus.
// - Service request pin returns high as soon as acknowledge is seen.
// - Clear then set of enable bit 4 ends the service.
// - Vector low bits: 4 channel, 5 pipeline, 6 both.
// - Status register bit mask 0x08 shows active service request.
// - DMA enabled and threshold exceeded sets status bit 7.
// - DMA data only through buffer register, needs 16-bit bus.
// - Irq register: bit7 pending, bit6 port, bit5 pipeline, rest zero.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "srah_defs.vh"

module srah_top
#(
    parameter BUF_DEPTH = 4,
    parameter BUF_AW    = 2
)
(
    input  wire        clock,
    input  wire        rst,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata_q,
    input  wire        svc_ack_n,
    input  wire        ack_rd,
    output reg  [15:0] ack_data_q,
    output reg         ack_data_oe_q,
    output reg         svc_req_n,
    input  wire        port_src,
    input  wire        pipe_src,
    input  wire [7:0]  fifo_level,
    input  wire [15:0] fifo_word,
    input  wire        fifo_word_vld,
    output reg         dma_req_q,
    output reg         irq_q
);

// ----------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------
reg  [7:0]  pctl_q;
reg  [7:0]  lvec_q;
reg  [7:0]  pvec_q;
reg         pend_q;
reg         port_q;
reg         pipe_q;
reg         armed_q;
reg         ien_low_q;
reg         cfg16_q;
reg  [1:0]  istat_q;
reg  [1:0]  imask_q;
reg  [BUF_AW-1:0] wptr_q;
reg  [BUF_AW-1:0] rptr_q;
reg  [7:0]  rsel_d;

wire        ack_lvl;
wire [15:0] dbuf_rdata;

srah_sync #(.RST_VAL(1'b1)) u_ack_sync
(
    .clock   (clock),
    .rst     (rst),
    .pin     (svc_ack_n),
    .level_q (ack_lvl)
);

srah_dbuf #(.WIDTH(16), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_dbuf
(
    .clock   (clock),
    .we      (fifo_word_vld),
    .waddr   (wptr_q),
    .wdata   (fifo_word),
    .raddr   (rptr_q),
    .rdata_q (dbuf_rdata)
);

// ----------------------------------------------------------------
// Decode
// ----------------------------------------------------------------
wire ack_seen  = ~ack_lvl;
wire wr_irq    = wr && (addr == `SRAH_A_IRQ);
wire wr_pctl   = wr && (addr == `SRAH_A_PCTL);
wire ien_new   = wdata[`SRAH_PCTL_IEN];
// Toggle complete: a clear followed by a set of the enable bit
wire eos       = wr_pctl & ien_new & ien_low_q;
wire dma_en    = pctl_q[`SRAH_PCTL_DMAEN];
wire src_any   = port_src | pipe_src;
wire new_req   = armed_q & ~pend_q & src_any & pctl_q[`SRAH_PCTL_IEN];
wire thr_hit   = dma_en & (fifo_level > `SRAH_FIFO_THR);
wire [7:0] irq_val = {pend_q, port_q, pipe_q, 5'h00};
wire [2:0] vcode;

assign vcode = (port_q & pipe_q) ? `SRAH_VEC_BOTH :
               port_q            ? `SRAH_VEC_PORT :
               pipe_q            ? `SRAH_VEC_PIPE : 3'h0;

// ----------------------------------------------------------------
// Request and service state
// ----------------------------------------------------------------
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        pend_q     <= 1'b0;
        port_q     <= 1'b0;
        pipe_q     <= 1'b0;
        armed_q    <= 1'b1;
        ien_low_q  <= 1'b0;
        svc_req_n  <= 1'b1;
    end
    else
    begin
        if (wr_pctl)
            ien_low_q <= ~ien_new | (ien_low_q & ~ien_new);
        if (eos)
            armed_q <= 1'b1;
        if (new_req)
        begin
            pend_q    <= 1'b1;
            port_q    <= port_src;
            pipe_q    <= pipe_src;
            armed_q   <= 1'b0;
            svc_req_n <= 1'b0;
        end
        else
        begin
            if (ack_seen)
                svc_req_n <= 1'b1;
            if (wr_irq && !wdata[`SRAH_IRQ_PEND])
            begin
                pend_q    <= 1'b0;
                svc_req_n <= 1'b1;
            end
            if (eos)
            begin
                pend_q <= 1'b0;
                port_q <= 1'b0;
                pipe_q <= 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------
// Software registers and interrupt status
// ----------------------------------------------------------------
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        pctl_q    <= `SRAH_RST_PCTL;
        lvec_q    <= `SRAH_RST_LVEC;
        pvec_q    <= `SRAH_RST_PVEC;
        cfg16_q   <= 1'b0;
        istat_q   <= 2'b00;
        imask_q   <= 2'b00;
        dma_req_q <= 1'b0;
        irq_q     <= 1'b0;
    end
    else
    begin
        if (wr_pctl)
            pctl_q <= wdata[7:0];
        if (wr && (addr == `SRAH_A_LVEC))
            lvec_q <= {wdata[7:3], 3'h0};
        if (wr && (addr == `SRAH_A_PVEC))
            pvec_q <= wdata[7:0];
        if (wr && (addr == `SRAH_A_CFG))
            cfg16_q <= wdata[`SRAH_CFG_BUS16];
        if (wr && (addr == `SRAH_A_IMASK))
            imask_q <= wdata[1:0];
        // Set wins over write-one-to-clear
        istat_q <= (istat_q & ~((wr && addr == `SRAH_A_ISTAT) ? wdata[1:0] : 2'b00))
                   | {thr_hit, new_req};
        dma_req_q <= thr_hit;
        irq_q     <= |(istat_q & imask_q);
    end
end

// ----------------------------------------------------------------
// DMA buffer pointers
// ----------------------------------------------------------------
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        wptr_q <= {BUF_AW{1'b0}};
        rptr_q <= {BUF_AW{1'b0}};
    end
    else
    begin
        if (fifo_word_vld)
            wptr_q <= wptr_q + 1'b1;
        // buffer reads only with DMA and wide bus
        if (rd && addr == `SRAH_A_DBUF && dma_en && cfg16_q)
            rptr_q <= rptr_q + 1'b1;
    end
end

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
// Byte register select; registered below so read data leave a flip-flop
always @*
begin
    rsel_d = 8'h00;
    if (addr == `SRAH_A_IRQ)
        rsel_d = irq_val;
    else if (addr == `SRAH_A_LVEC)
        rsel_d = {lvec_q[7:3], vcode};
    else if (addr == `SRAH_A_PVEC)
        rsel_d = pvec_q;
    else if (addr == `SRAH_A_STAT)
        rsel_d = {dma_req_q, 3'h0, pend_q, 3'h0};
    else if (addr == `SRAH_A_PCTL)
        rsel_d = pctl_q;
    else if (addr == `SRAH_A_FSTAT)
        rsel_d = fifo_level;
    else if (addr == `SRAH_A_ISTAT)
        rsel_d = {6'h00, istat_q};
    else if (addr == `SRAH_A_IMASK)
        rsel_d = {6'h00, imask_q};
    else if (addr == `SRAH_A_CFG)
        rsel_d = {7'h00, cfg16_q};
    else
        rsel_d = 8'h00;
end

always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        rdata_q       <= 16'h0000;
        ack_data_q    <= 16'h0000;
        ack_data_oe_q <= 1'b0;
    end
    else
    begin
        // Buffer word already stands in the memory register while the pointer rests
        if (rd && addr == `SRAH_A_DBUF)
            rdata_q <= (dma_en & cfg16_q) ? dbuf_rdata : 16'h0000;
        else if (rd)
            rdata_q <= {8'h00, rsel_d};
        else
            rdata_q <= 16'h0000;
        ack_data_oe_q <= ack_rd & ack_seen;
        ack_data_q    <= (ack_rd & ack_seen) ? {8'h00, lvec_q[7:3], vcode} : 16'h0000;
    end
end

endmodule
`default_nettype wire

// ===== srah_defs.vh
// Purpose: Shared constants of the service request and acknowledge handler.
// Assumes: Byte-wide registers, word-spaced offsets on the plain register port.
// Notes:   Offsets are byte addresses; upper data bits read as zero except at the 16-bit buffer register.
`ifndef SRAH_DEFS_VH
`define SRAH_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SRAH_A_IRQ       8'h00
`define SRAH_A_LVEC      8'h04
`define SRAH_A_PVEC      8'h08
`define SRAH_A_STAT      8'h0c
`define SRAH_A_PCTL      8'h10
`define SRAH_A_FSTAT     8'h14
`define SRAH_A_DBUF      8'h18
`define SRAH_A_ISTAT     8'h1c
`define SRAH_A_IMASK     8'h20
`define SRAH_A_CFG       8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SRAH_IRQ_PEND    7
`define SRAH_IRQ_PORT    6
`define SRAH_IRQ_PIPE    5
`define SRAH_STAT_DMA    7
`define SRAH_STAT_SREQ   3
`define SRAH_PCTL_DMAEN  7
`define SRAH_PCTL_IEN    4
`define SRAH_CFG_BUS16   0

// ----------------------------------------------------------------
// Vector codes, reset values and FIFO threshold
// ----------------------------------------------------------------
`define SRAH_VEC_PORT    3'h4
`define SRAH_VEC_PIPE    3'h5
`define SRAH_VEC_BOTH    3'h6
`define SRAH_RST_PCTL    8'h00
`define SRAH_RST_LVEC    8'h00
`define SRAH_RST_PVEC    8'h00
`define SRAH_RST_MASK    8'h00
`define SRAH_FIFO_THR    8'h20

`endif

// ===== srah_sync.v
// Purpose: Three-stage synchroniser for one pin.
// Assumes: Input is asynchronous to clock.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module srah_sync
#(
    parameter RST_VAL = 1'b1
)
(
    input  wire clock,
    input  wire rst,
    input  wire pin,
    output reg  level_q
);

reg  s1_q;
reg  s2_q;
reg  s3_q;

always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        s1_q    <= RST_VAL;
        s2_q    <= RST_VAL;
        s3_q    <= RST_VAL;
        level_q <= RST_VAL;
    end
    else
    begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // Stage one feeds stage two only
        if (s2_q == s3_q)
            level_q <= s3_q;
    end
end

endmodule
`default_nettype wire

// ===== srah_dbuf.v
// Purpose: Small word store for the DMA buffer path.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data come from a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module srah_dbuf
#(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire             clock,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    input  wire [AW-1:0]    raddr,
    output reg  [WIDTH-1:0] rdata_q
);

reg  [WIDTH-1:0] mem [0:DEPTH-1];

always @(posedge clock)
begin
    if (we)
        mem[waddr] <= wdata;
    rdata_q <= mem[raddr];
end

endmodule
`default_nettype wire

// ===== srah_properties.sv
// Purpose: Port checks of the service request handler.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   Sees only srah_top ports.
`timescale 1ns/1ps
`default_nettype none
`include "srah_defs.vh"

module srah_properties
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata_q,
    input wire logic        svc_ack_n,
    input wire logic        ack_rd,
    input wire logic [15:0] ack_data_q,
    input wire logic        ack_data_oe_q,
    input wire logic        svc_req_n,
    input wire logic        port_src,
    input wire logic        pipe_src,
    input wire logic [7:0]  fifo_level,
    input wire logic        dma_req_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // Steps
    // ----
    // Long enough to cover the pin synchroniser
    sequence ack_held;
        !svc_ack_n [*8];
    endsequence
    sequence no_ctl_wr;
        !(wr && addr == `SRAH_A_PCTL) [*8];
    endsequence
    chk_req_ack_drop: assert property (ack_held |-> svc_req_n)
        else $error("request kept under ack");
    chk_ack_vec_code: assert property (ack_data_oe_q |-> ack_data_q[2] && !(&ack_data_q[1:0]))
        else $error("bad vector code");
    chk_ack_oe_cause: assert property (ack_data_oe_q |-> $past(ack_rd))
        else $error("vector driven without ack read");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata_q == 16'h0000)
        else $error("read data outside read");
    chk_irq_low_zero: assert property ($past(rd) && $past(addr) == `SRAH_A_IRQ |-> rdata_q[4:0] == 5'h00)
        else $error("irq low bits set");
    chk_dma_over_thr: assert property (dma_req_q |-> $past(fifo_level) > `SRAH_FIFO_THR)
        else $error("dma flag below threshold");
    chk_no_rearm: assert property ($rose(svc_req_n) ##1 no_ctl_wr |-> svc_req_n)
        else $error("request before end of service");
    chk_req_has_src: assert property ($fell(svc_req_n) |-> $past(port_src || pipe_src))
        else $error("request without source");
endmodule

bind srah_top srah_properties u_chk (.clock, .rst, .addr, .wr, .rd, .rdata_q, .svc_ack_n, .ack_rd,
    .ack_data_q, .ack_data_oe_q, .svc_req_n, .port_src, .pipe_src, .fifo_level, .dma_req_q);
`default_nettype wire

// ===== srah_host_model.sv
// Purpose: Host side of the acknowledge cycle.
// Assumes: go and slow come from the bench.
// Notes:   slow adds four wait cycles before the pin.
`timescale 1ns/1ps
`default_nettype none

module srah_host_model
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic svc_req_n,
    input  wire logic go,
    input  wire logic slow,
    output wire logic svc_ack_n,
    output wire logic ack_rd
);
    logic [3:0] cnt_q;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        else if (go && !svc_req_n)
            cnt_q <= slow ? 4'hf : 4'hb;
    end
    assign svc_ack_n = !(cnt_q != 4'h0 && cnt_q <= 4'ha);
    assign ack_rd    = cnt_q > 4'h1 && cnt_q <= 4'ha;
endmodule
`default_nettype wire

// ===== test_service_request_ack_handler.sv
// Purpose: Self-checking bench of the request handler.
// Assumes: Host model runs the acknowledge cycles.
// Notes:   Sources are plain levels.
`timescale 1ns/1ps
`default_nettype none
`include "srah_defs.vh"

module test_service_request_ack_handler;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        port_src = 1'b0;
    logic        pipe_src = 1'b0;
    logic [7:0]  fifo_level = 8'h00;
    logic [15:0] fifo_word = 16'h0000;
    logic        fifo_word_vld = 1'b0;
    logic        go = 1'b0;
    logic        slow = 1'b0;
    wire  [15:0] rdata_q;
    wire  [15:0] ack_data_q;
    wire         svc_ack_n;
    wire         ack_rd;
    wire         ack_data_oe_q;
    wire         svc_req_n;
    wire         dma_req_q;
    wire         irq_q;
    int          errors = 0;
    int          num_checks = 0;
    int          k;

    always #10 clock = ~clock;

    srah_top DUT (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata_q, .svc_ack_n, .ack_rd, .ack_data_q,
        .ack_data_oe_q, .svc_req_n, .port_src, .pipe_src, .fifo_level, .fifo_word, .fifo_word_vld,
        .dma_req_q, .irq_q);
    srah_host_model u_host (.clock, .rst, .svc_req_n, .go, .slow, .svc_ack_n, .ack_rd);

    // ----
    // Tasks
    // ----
    task automatic end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task automatic check(input [15:0] s, input [15:0] e);
        begin
            num_checks++;
            if (s !== e)
            begin
                errors++;
                $display("BAD t=%0t seen %h exp %h", $time, s, e);
            end
        end
    endtask

    task automatic wr_reg(input [7:0] a, input [15:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
            @(posedge clock);
        end
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd_reg(input [7:0] a, input [15:0] m, input [15:0] e);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            @(negedge clock);
            check(rdata_q & m, e);
            @(posedge clock);
        end
    endtask

    task automatic pin_chk(input int w, input logic e);
        begin
            @(negedge clock);
            check({15'h0, w == 0 ? irq_q : svc_req_n}, {15'h0, e});
            @(posedge clock);
        end
    endtask

    // Ends at a falling edge; the caller realigns
    task automatic wait_for(input int w);
        int i;
        begin
            for (i = 0; i < 60; i++)
            begin
                @(negedge clock);
                if (w == 0 ? svc_req_n === 1'b0 : w == 1 ? ack_data_oe_q === 1'b1 : svc_req_n === 1'b1)
                    break;
            end
            if (i == 60)
            begin
                errors++;
                $display("BAD t=%0t wait %0d ran out", $time, w);
                end_sim;
            end
        end
    endtask

    // ----
    // Sequence
    // ----
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd_reg(`SRAH_A_IRQ, 16'hffff, 16'h0000);
        rd_reg(8'h30, 16'hffff, 16'h0000);
        wr_reg(8'h30, 16'h00ff);
        rd_reg(`SRAH_A_PCTL, 16'hffff, {8'h00, `SRAH_RST_PCTL});
        wr_reg(`SRAH_A_PCTL, 16'h0010);
        // Channel only, pipeline only, both
        for (k = 0; k < 3; k++)
        begin
            port_src <= k != 1;
            pipe_src <= k != 0;
            wait_for(0);
            @(posedge clock);
            rd_reg(`SRAH_A_STAT, 16'h0008, 16'h0008);
            rd_reg(`SRAH_A_LVEC, 16'hffff, 16'(k + 4));
            rd_reg(`SRAH_A_IRQ, 16'hffff, {8'h00, 1'b1, k != 1, k != 0, 5'h00});
            if (k == 0)
            begin
                rd_reg(`SRAH_A_ISTAT, 16'h0001, 16'h0001);
                pin_chk(0, 1'b0);
                wr_reg(`SRAH_A_IMASK, 16'h0001);
                pin_chk(0, 1'b1);
                wr_reg(`SRAH_A_ISTAT, 16'h0001);
                pin_chk(0, 1'b0);
                wr_reg(`SRAH_A_IMASK, 16'h0000);
            end
            if (k == 1)
            begin
                rd_reg(`SRAH_A_PVEC, 16'hffff, {8'h00, `SRAH_RST_PVEC});
                wr_reg(`SRAH_A_IRQ, 16'h0000);
            end
            else
            begin
                slow <= k == 2;
                go <= 1'b1;
                wait_for(1);
                check(ack_data_q, 16'(k + 4));
                @(posedge clock);
                go <= 1'b0;
            end
            wait_for(2);
            @(posedge clock);
            repeat (20) @(posedge clock);
            pin_chk(1, 1'b1);
            port_src <= 1'b0;
            pipe_src <= 1'b0;
            wr_reg(`SRAH_A_PCTL, 16'h0000);
            wr_reg(`SRAH_A_PCTL, 16'h0010);
        end
        wr_reg(`SRAH_A_CFG, 16'h0001);
        wr_reg(`SRAH_A_PCTL, 16'h0090);
        fifo_level <= `SRAH_FIFO_THR;
        repeat (3) @(posedge clock);
        rd_reg(`SRAH_A_STAT, 16'h0080, 16'h0000);
        rd_reg(`SRAH_A_FSTAT, 16'hffff, {8'h00, `SRAH_FIFO_THR});
        fifo_level <= `SRAH_FIFO_THR + 8'h01;
        repeat (3) @(posedge clock);
        rd_reg(`SRAH_A_STAT, 16'h0080, 16'h0080);
        fifo_word <= 16'hbeef;
        fifo_word_vld <= 1'b1;
        @(posedge clock);
        fifo_word_vld <= 1'b0;
        @(posedge clock);
        rd_reg(`SRAH_A_DBUF, 16'hffff, 16'hbeef);
        wr_reg(`SRAH_A_CFG, 16'h0000);
        rd_reg(`SRAH_A_DBUF, 16'hffff, 16'h0000);
        end_sim;
    end
endmodule
`default_nettype wire
